// ---- shared/slow_init_pkg.sv ----
// Package for the slow-init header responder: timing counts, bytes, states.
// Assumes a 100 MHz system clock; counts derive from times in their own units, the link bit count from its bit rate.
package slow_init_pkg;
   localparam int CLK_HZ = 100_000_000;
   // Address bit rate of 5 bit/s, one bit lasts 200 ms.
   localparam int ADDR_BIT_MS = 200;
   localparam int ADDR_BIT_CYC = ADDR_BIT_MS * (CLK_HZ / 1000);
   // Header and later traffic run at 10400 bit/s; rounded down to whole cycles.
   localparam int LINK_BPS = 10400;
   localparam int LINK_BIT_CYC = CLK_HZ / LINK_BPS;
   // Least gap from address stop bit to sync pattern, rounded up.
   localparam int ADDR_TO_SYNC_MS = 60;
   localparam int ADDR_TO_SYNC_CYC = ADDR_TO_SYNC_MS * (CLK_HZ / 1000);
   // Gap values are not fixed here; plain short defaults in microseconds, to be set per product.
   localparam int SYNC_TO_KEY_US = 20;
   localparam int SYNC_TO_KEY_CYC = SYNC_TO_KEY_US * (CLK_HZ / 1_000_000);
   localparam int KEY_GAP_US = 20;
   localparam int KEY_GAP_CYC = KEY_GAP_US * (CLK_HZ / 1_000_000);
   localparam int HS_WINDOW_US = 200;
   localparam int HS_WINDOW_CYC = HS_WINDOW_US * (CLK_HZ / 1_000_000);
   localparam int HS_REPLY_US = 1;
   localparam int HS_REPLY_CYC = HS_REPLY_US * (CLK_HZ / 1_000_000);
   // Bytes of the header, and the receive FIFO depth.
   localparam logic [7:0] STD_ADDR = 8'h33;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam logic [6:0] KEY1_DEF = 7'h08;
   localparam logic [6:0] KEY2_DEF = 7'h08;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_W1 = 4'b0010,
      ST_SYNC = 4'b0011,
      ST_W2 = 4'b0100,
      ST_KEY1 = 4'b0101,
      ST_W3 = 4'b0110,
      ST_KEY2 = 4'b0111,
      ST_HS = 4'b1000,
      ST_W4 = 4'b1001,
      ST_INV = 4'b1010,
      ST_DONE = 4'b1011
   } init_state_t;

   // Odd parity bit for a 7-bit key word.
   function automatic logic odd_par(input logic [6:0] k);
      odd_par = ~(^k);
   endfunction : odd_par
endpackage : slow_init_pkg

// ---- core/si_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain shared by filler and drainer.
`timescale 1ns/1ps
module si_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_t;
   fifo_t s_r, s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   // Handshakes are combinational; storage is flip-flops.
   assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[s_r.rp];

   // Pointers wrap at DEPTH so non-power-of-two depths stay honest.
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // The array has no reset; the count keeps stale words unseen.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[s_r.wp] <= in_data;
      end
   end

   a_fifo_no_over: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_r.cnt <= (AW+1)'(DEPTH)) else $error("FIFO count beyond depth.");
endmodule : si_fifo

// ---- core/si_bit_tx.sv ----
// NRZ frame shifter: start bit, 8 data bits LSB first, stop bit.
// Assumes the caller holds start high for one cycle while busy is low.
`timescale 1ns/1ps
module si_bit_tx #(
   parameter int BIT_CYC = 9615
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [7:0] data,
   output logic busy,
   output logic done,
   output logic line
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [9:0] sh;
      logic [3:0] nb;
      logic [15:0] cnt;
   } tx_t;
   tx_t s_r, s_nxt;

   // Each level is held for the whole bit period, no return to rest.
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!s_r.busy) begin
         if (start) begin
            s_nxt.busy = 1'b1;
            s_nxt.sh = {1'b1, data, 1'b0};
            s_nxt.nb = 4'd9;
            s_nxt.cnt = 16'(BIT_CYC - 1);
         end
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end else if (s_r.nb == '0) begin
         s_nxt.busy = 1'b0;
         s_nxt.done = 1'b1;
         s_nxt.sh = 10'h3FF;
      end else begin
         s_nxt.sh = {1'b1, s_r.sh[9:1]};
         s_nxt.nb = s_r.nb - 1'b1;
         s_nxt.cnt = 16'(BIT_CYC - 1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{busy: 1'b0, done: 1'b0, sh: 10'h3FF, nb: 4'h0, cnt: 16'h0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign done = s_r.done;
   assign line = s_r.busy ? s_r.sh[0] : 1'b1;

   a_tx_start_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (start && !busy) |=> !line) else $error("Start bit not low.");
endmodule : si_bit_tx

// ---- core/slow_init_responder.sv ----
// Control-unit end of the slow-init header on the K and L diagnostic lines.
// Assumes K and L arrive through level shifters as logic levels; K is open drain.
// Contract
// - NRZ levels held each whole bit
// - Decode address; 0x33 selects standard format
// - Frame: low start, 8 LSB first, high stop
// - Hold K high at least 60 ms
// - Send sync byte 0x55 framed
// - Hold K high for sync-to-key gap
// - Send exactly two key words
// - Key frame: start, 7 bits, parity, stop
// - Key parity makes ones count odd
// - Reply with inverted address within window
// - Key word selects the response gap
// - Header runs at 10400 bit/s
`timescale 1ns/1ps
module slow_init_responder
   import slow_init_pkg::*;
#(
   parameter int ADDR_BIT = ADDR_BIT_CYC,
   parameter int LINK_BIT = LINK_BIT_CYC,
   parameter int W1_CYC = ADDR_TO_SYNC_CYC,
   parameter int W2_CYC = SYNC_TO_KEY_CYC,
   parameter int W3_CYC = KEY_GAP_CYC,
   parameter int W4_CYC = HS_WINDOW_CYC,
   parameter int REPLY_CYC = HS_REPLY_CYC,
   parameter logic [6:0] KEY1 = KEY1_DEF,
   parameter logic [6:0] KEY2 = KEY2_DEF
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic k_in,
   output logic k_out,
   output logic k_oe_n,
   input wire logic l_in,
   input wire logic [7:0] addr_accept,
   input wire logic enable,
   output logic init_done,
   output logic std_format,
   output logic [7:0] init_addr,
   output logic init_fail,
   output logic [6:0] gap_key,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   typedef struct packed {
      init_state_t st;
      logic [31:0] tmr;
      logic [3:0] bit_n;
      logic [7:0] sh;
      logic [7:0] addr;
      logic busy_rx;
      logic last_k;
      logic done;
      logic fail;
      logic std;
      logic tx_go;
      logic [7:0] tx_byte;
      logic push;
      logic [7:0] push_d;
   } top_t;
   top_t s_r, s_nxt;

   logic k_m, k_s, l_m, l_s, kl;
   logic tx_busy, tx_done, tx_line, f_ready;
   logic [31:0] slow_rx_bit;

   // Two flops on each pin before any logic reads it.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         k_m <= 1'b1;
         k_s <= 1'b1;
         l_m <= 1'b1;
         l_s <= 1'b1;
      end else begin
         k_m <= k_in;
         k_s <= k_m;
         l_m <= l_in;
         l_s <= l_m;
      end
   end

   // Address may come on K, L or both; a low on either counts as a zero.
   assign kl = k_s & l_s;
   // Byte receive bit period: slow during address, link rate afterwards.
   assign slow_rx_bit = (s_r.st == ST_IDLE || s_r.st == ST_ADDR) ? 32'(ADDR_BIT) : 32'(LINK_BIT);

   // The transmitter runs at the link rate for the whole header.
   si_bit_tx #(.BIT_CYC(LINK_BIT)) u_tx (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(s_r.tx_go),
      .data(s_r.tx_byte),
      .busy(tx_busy),
      .done(tx_done),
      .line(tx_line)
   );

   // Received handshake bytes are offered to the user; a full FIFO stalls the push, and a later handshake byte overwrites the one held.
   si_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_data(s_r.push_d),
      .in_valid(s_r.push),
      .in_ready(f_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   // Header sequencer and a simple mid-bit sampling receiver.
   always_comb begin
      s_nxt = s_r;
      s_nxt.tx_go = 1'b0;
      if (s_r.push && f_ready) begin
         s_nxt.push = 1'b0;
      end
      if (s_r.tmr != '0) begin
         s_nxt.tmr = s_r.tmr - 1'b1;
      end
      case (s_r.st)
         ST_IDLE: begin
            if (enable && !kl) begin
               s_nxt.st = ST_ADDR;
               s_nxt.tmr = 32'(ADDR_BIT / 2);
               s_nxt.bit_n = 4'd0;
            end
         end
         ST_ADDR, ST_HS: begin
            if (s_r.tmr == '0) begin
               if (s_r.bit_n == 4'd0 && (s_r.st == ST_ADDR ? kl : k_s)) begin
                  s_nxt.st = ST_IDLE; // Glitch start bit.
               end else if (s_r.bit_n == 4'd9) begin
                  if (!(s_r.st == ST_ADDR ? kl : k_s)) begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.fail = 1'b1;
                  end else if (s_r.st == ST_ADDR) begin
                     s_nxt.addr = s_r.sh;
                     // Only decoded addresses are answered.
                     if (s_r.sh == STD_ADDR || s_r.sh == addr_accept) begin
                        s_nxt.std = (s_r.sh == STD_ADDR);
                        s_nxt.st = ST_W1;
                        // Stop sampled mid-bit, so the remaining half bit is added to reach the stop bit's end.
                        s_nxt.tmr = 32'(W1_CYC + ADDR_BIT / 2);
                        s_nxt.fail = 1'b0;
                        s_nxt.done = 1'b0;
                     end else begin
                        s_nxt.st = ST_IDLE;
                     end
                  end else if (s_r.sh == ~{odd_par(KEY2), KEY2}) begin
                     s_nxt.st = ST_W4;
                     // Wait out the tester's stop bit first, so the reply never collides with it.
                     s_nxt.tmr = 32'(REPLY_CYC + LINK_BIT / 2);
                  end else begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.fail = 1'b1;
                  end
                  if (s_r.st == ST_HS) begin
                     s_nxt.push = 1'b1;
                     s_nxt.push_d = s_r.sh;
                  end
               end else begin
                  if (s_r.bit_n != 4'd0) begin
                     s_nxt.sh = {(s_r.st == ST_ADDR ? kl : k_s), s_r.sh[7:1]};
                  end
                  s_nxt.bit_n = s_r.bit_n + 1'b1;
                  s_nxt.tmr = slow_rx_bit - 1;
               end
            end
         end
         ST_W1: begin
            if (s_r.tmr == '0) begin
               s_nxt.st = ST_SYNC;
               s_nxt.tx_go = 1'b1;
               s_nxt.tx_byte = SYNC_BYTE;
            end
         end
         ST_SYNC, ST_KEY1, ST_KEY2: begin
            if (tx_done) begin
               s_nxt.st = (s_r.st == ST_SYNC) ? ST_W2 : (s_r.st == ST_KEY1) ? ST_W3 : ST_HS;
               s_nxt.tmr = (s_r.st == ST_SYNC) ? 32'(W2_CYC) : (s_r.st == ST_KEY1) ? 32'(W3_CYC) : 32'(W4_CYC);
               s_nxt.bit_n = 4'd0;
            end
         end
         ST_W2, ST_W3: begin
            if (s_r.tmr == '0) begin
               // Two key words only, parity odd over all eight bits.
               s_nxt.st = (s_r.st == ST_W2) ? ST_KEY1 : ST_KEY2;
               s_nxt.tx_go = 1'b1;
               s_nxt.tx_byte = (s_r.st == ST_W2) ? {odd_par(KEY1), KEY1} : {odd_par(KEY2), KEY2};
            end
         end
         ST_W4: begin
            if (s_r.tmr == '0) begin
               s_nxt.st = ST_INV;
               s_nxt.tx_go = 1'b1;
               s_nxt.tx_byte = ~s_r.addr;
            end
         end
         ST_INV: begin
            if (tx_done) begin
               s_nxt.st = ST_DONE;
               s_nxt.done = 1'b1;
            end
         end
         ST_DONE: begin
            if (!enable) begin
               s_nxt.st = ST_IDLE;
               s_nxt.done = 1'b0;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
      // Handshake wait: a start edge begins the byte, the window expiring abandons it.
      if (s_r.st == ST_HS && s_r.bit_n == 4'd0 && !s_r.busy_rx) begin
         if (!k_s) begin
            s_nxt.busy_rx = 1'b1;
            s_nxt.tmr = 32'(LINK_BIT / 2);
         end else if (s_r.tmr == '0) begin
            s_nxt.st = ST_IDLE;
            s_nxt.fail = 1'b1;
         end
      end
      if (s_nxt.st != ST_HS) begin
         s_nxt.busy_rx = 1'b0;
      end
      if (!enable) begin
         s_nxt.st = ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{st: ST_IDLE, tx_byte: 8'hFF, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // K is open drain: enable low pulls the line low, released otherwise.
   assign k_out = 1'b0;
   assign k_oe_n = tx_line;
   assign init_done = s_r.done;
   assign init_fail = s_r.fail;
   assign std_format = s_r.std;
   assign init_addr = s_r.addr;
   // The user takes this key as the selector of its response gap.
   assign gap_key = KEY2;

   a_w1_high_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.st == ST_W1) |-> k_oe_n) else $error("K pulled low during address-to-sync gap.");
   a_sync_after_w1: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.st == ST_W1 && s_r.tmr == '0) |=> s_r.tx_go && s_r.tx_byte == SYNC_BYTE)
      else $error("Sync byte not launched after gap.");
   a_key_parity: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.tx_go && (s_r.st == ST_KEY1 || s_r.st == ST_KEY2)) |-> ^s_r.tx_byte)
      else $error("Key word parity not odd.");
   a_inv_addr: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.tx_go && s_r.st == ST_INV) |-> s_r.tx_byte == ~s_r.addr)
      else $error("Reply is not the inverted address.");
   a_w2_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.st == ST_W2 || s_r.st == ST_W3) |-> k_oe_n) else $error("K low in key gap.");
   a_hs_timeout: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.st == ST_HS && s_r.bit_n == 4'd0 && !s_r.busy_rx && k_s && s_r.tmr == '0 && enable)
      |=> s_r.st == ST_IDLE && s_r.fail) else $error("Handshake timeout not abandoned.");
   a_two_keys: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (s_r.st == ST_KEY2 && tx_done && enable) |=> s_r.st == ST_HS) else $error("Extra key word.");
   a_std_decode: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(s_r.st == ST_W1) |-> s_r.std == (s_r.addr == STD_ADDR)) else $error("Address decode wrong.");
endmodule : slow_init_responder

// ---- verification/scan_tester_model.sv ----
// Behavioural tester on the diagnostic lines: sends the slow address, reads the header, returns the handshake.
// Assumes the bench resolves K and L with pull-ups and feeds the K level back on k_line.
`timescale 1ns/1ps
module scan_tester_model #(
   parameter int ADDR_BIT = 200
) (
   input wire logic clk_sys,
   input wire logic k_line,
   output logic k_low,
   output logic l_low
);
   int bit_cyc = 9615;

   // Both lines start released so the pull-ups hold them high.
   initial begin
      k_low = 1'b0;
      l_low = 1'b0;
   end

   // Every driver moves just after the rising edge, never on it.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // One frame: low start, data LSB first, high stop, each level held a whole bit.
   task automatic send_frame(input logic [7:0] b, input int cyc, input bit both);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         k_low = ~f[i];
         l_low = both & ~f[i];
         tick(cyc);
      end
   endtask : send_frame

   // Receives one frame sampled mid-bit; got holds the stop level in bit 8.
   task automatic recv(input bit measure, output logic [8:0] got, output bit seen);
      int n;
      got = '0;
      seen = 1'b0;
      n = 0;
      while (k_line !== 1'b0 && n < 5000) begin
         tick(1);
         n++;
      end
      if (k_line !== 1'b0) return;
      if (measure) begin
         n = 0;
         while (k_line === 1'b0 && n < 20000) begin
            tick(1);
            n++;
         end
         // The start bit of the pattern sets the rate for all later bytes.
         bit_cyc = n;
         tick(bit_cyc / 2);
      end else begin
         tick(bit_cyc + bit_cyc / 2);
      end
      for (int i = 0; i < 8; i++) begin
         got[i] = k_line;
         tick(bit_cyc);
      end
      got[8] = k_line;
      seen = 1'b1;
   endtask : recv

   // Whole initialisation; a corrupt handshake flips the lowest bit of the inverted key.
   task automatic header(input logic [7:0] addr, input bit corrupt, output logic [8:0] rx [4],
                         output int gap, output int seen);
      bit ok;
      int n;
      seen = 0;
      gap = 0;
      foreach (rx[i]) rx[i] = '0;
      k_low = 1'b0;
      l_low = 1'b0;
      tick(50);
      send_frame(addr, ADDR_BIT, 1'b1);
      n = 0;
      while (k_line === 1'b1 && n < 5000) begin
         tick(1);
         n++;
      end
      gap = n;
      for (int i = 0; i < 3; i++) begin
         recv(i == 0, rx[i], ok);
         if (!ok) return;
         seen++;
      end
      tick(100);
      send_frame(~rx[2][7:0] ^ {7'h00, corrupt}, bit_cyc, 1'b0);
      recv(1'b0, rx[3], ok);
      if (ok) seen++;
   endtask : header
endmodule : scan_tester_model

// ---- verification/testbench.sv ----
// Self-checking bench for the slow-init responder with a tester model on the K and L lines.
// Assumes the package constants and a 100 MHz clock; the address and link bit times are shortened by parameter, so runs stay short.
`timescale 1ns/1ps
module testbench
   import slow_init_pkg::*;
;
   localparam logic [6:0] KEY1 = KEY1_DEF;
   localparam logic [6:0] KEY2 = 7'h14;
   localparam int W1 = 1000;
   // Shortened address and link bit times keep the run small.
   localparam int AB = 200;
   localparam int LB = 50;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic enable = 1'b1;
   logic rx_ready = 1'b0;
   logic [7:0] addr_accept = 8'h00;
   logic k_out, k_oe_n, init_done, std_format, init_fail, rx_valid, k_low, l_low;
   logic [7:0] init_addr, rx_data;
   logic [6:0] gap_key;
   int mismatches = 0;
   int compares = 0;

   // Open-drain K and driven L, both pulled up when nobody pulls low.
   wire k_line = ~k_low & (k_oe_n | k_out);
   wire l_line = ~l_low;

   always #5 clk_sys = ~clk_sys;

   slow_init_responder #(.ADDR_BIT(AB), .LINK_BIT(LB), .W1_CYC(W1), .KEY2(KEY2)) uut (
      .clk_sys(clk_sys), .arst_n(arst_n), .k_in(k_line), .k_out(k_out), .k_oe_n(k_oe_n), .l_in(l_line),
      .addr_accept(addr_accept), .enable(enable), .init_done(init_done), .std_format(std_format),
      .init_addr(init_addr), .init_fail(init_fail), .gap_key(gap_key), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready));

   scan_tester_model #(.ADDR_BIT(AB)) partner (
      .clk_sys(clk_sys), .k_line(k_line), .k_low(k_low), .l_low(l_low));

   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   // Standard address with a correct handshake; the FIFO is left holding its byte for later.
   task automatic standard_header();
      logic [8:0] rx [4];
      int gap;
      int seen;
      partner.header(8'h33, 1'b0, rx, gap, seen);
      check("address to sync gap", {8'h00, gap >= W1}, 9'h001);
      check("bit period", {8'h00, partner.bit_cyc >= LB - 2 && partner.bit_cyc <= LB + 2},
            9'h001);
      check("sync byte", rx[0], 9'h155);
      check("first key", rx[1], {1'b1, ~^KEY1, KEY1});
      check("second key", rx[2], {1'b1, ~^KEY2, KEY2});
      check("inverted address", rx[3], 9'h1CC);
      check("bytes heard", 9'(seen), 9'h004);
      partner.tick(LB);
      check("done", {8'h00, init_done}, 9'h001);
      check("standard format", {8'h00, std_format}, 9'h001);
      check("address", {1'b0, init_addr}, 9'h033);
      check("fail", {8'h00, init_fail}, 9'h000);
      check("gap key", {2'b00, gap_key}, {2'b00, KEY2});
   endtask : standard_header

   // An address that is neither standard nor accepted gets no answer at all.
   task automatic refused_address();
      logic [8:0] rx [4];
      int gap;
      int seen;
      enable = 1'b0;
      partner.tick(5);
      enable = 1'b1;
      partner.tick(5);
      partner.header(8'h21, 1'b0, rx, gap, seen);
      check("refused bytes", 9'(seen), 9'h000);
      check("refused line", {8'h00, k_oe_n}, 9'h001);
      check("refused done", {8'h00, init_done}, 9'h000);
   endtask : refused_address

   // Accepted custom address, then a wrong handshake: no inverted address, sticky fail.
   task automatic wrong_handshake();
      logic [8:0] rx [4];
      int gap;
      int seen;
      addr_accept = 8'h5A;
      partner.tick(1);
      partner.header(8'h5A, 1'b1, rx, gap, seen);
      check("custom sync", rx[0], 9'h155);
      check("custom bytes", 9'(seen), 9'h003);
      check("custom fail", {8'h00, init_fail}, 9'h001);
      check("custom done", {8'h00, init_done}, 9'h000);
      check("custom format", {8'h00, std_format}, 9'h000);
   endtask : wrong_handshake

   // The reader stalled so far; the oldest handshake comes out first, then the FIFO empties.
   task automatic drain_fifo();
      check("fifo valid", {8'h00, rx_valid}, 9'h001);
      check("fifo head", {1'b0, rx_data}, {1'b0, ~{~^KEY2, KEY2}});
      rx_ready = 1'b1;
      partner.tick(1);
      rx_ready = 1'b0;
      partner.tick(1);
      check("fifo second", {1'b0, rx_data}, {1'b0, ~{~^KEY2, KEY2} ^ 8'h01});
      for (int i = 0; i < 9 && rx_valid === 1'b1; i++) begin
         rx_ready = 1'b1;
         partner.tick(1);
         rx_ready = 1'b0;
         partner.tick(1);
      end
      check("fifo empty", {8'h00, rx_valid}, 9'h000);
   endtask : drain_fifo

   // Reset held for eight cycles, then the scenarios in order.
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      partner.tick(5);
      standard_header();
      refused_address();
      wrong_handshake();
      drain_fifo();
      results();
   end
endmodule : testbench
